/* File: hdl/rct_consts.svh */
`ifndef RCT_CONSTS_SVH
`define RCT_CONSTS_SVH

// register byte offsets
`define RCT_OFS_IMSC 12'h01C
`define RCT_OFS_RIS  12'h020
`define RCT_OFS_MIS  12'h024
`define RCT_OFS_ICR  12'h028
`define RCT_OFS_TDR  12'h02C
`define RCT_OFS_TCR  12'h030
`define RCT_OFS_TLR1 12'h034
`define RCT_OFS_TLR2 12'h038
`define RCT_OFS_TPR1 12'h03C
`define RCT_OFS_TPR4 12'h048
`define RCT_OFS_TIN  12'h04C

// control register fields
`define RCT_TCR_RUN     0
`define RCT_TCR_OS      1
`define RCT_TCR_SS      2
`define RCT_TCR_PLEN_LO 4
`define RCT_TCR_PLEN_HI 10

// interrupt bit in mask, status and clear registers
`define RCT_IRQ_TMR 0

// count reset value and largest pattern length
`define RCT_TDR_RST 32'h0FFFFFFF
`define RCT_PLEN_MAX 7'h7F

`endif

/* File: hdl/rct_pkg.sv */
`default_nettype none
package rct_pkg;
    // run state of the countdown
    typedef enum logic [1:0] {
        RCT_STOPPED,
        RCT_RUNNING,
        RCT_HALTED
    } rct_tstate_t;

    // whole state of the timer module
    typedef struct packed {
        rct_tstate_t  tstate;
        logic [31:0]  count;
        logic [31:0]  reload1;
        logic [31:0]  reload2;
        logic [127:0] pattern;
        logic [6:0]   patLen;
        logic [6:0]   patIdx;
        logic         oneshotSelect;
        logic         selfStart;
        logic         irqMask;
        logic         countdownIrq;
        logic [31:0]  irqNumber;
        logic         combinedIrq;
        logic [31:0]  rdData;
        logic         rdErr;
    } rct_state_t;

    // synchroniser state of the tick generator
    typedef struct packed {
        logic sync1;
        logic sync2;
        logic sync3;
        logic tick;
    } rct_tick_t;
endpackage
`default_nettype wire

/* File: hdl/rct_ls_tick.sv */
`default_nettype none
module rct_ls_tick
    import rct_pkg::*;
(
    // system clock and reset
    input  wire logic mclk,
    input  wire logic rstn,
    // low-speed clock pin and power state
    input  wire logic lsClk,
    input  wire logic lowPower,
    // one-cycle pulse per low-speed rising edge, none while lowPower is high
    output logic      lsTick
);
    rct_tick_t s_reg;
    rct_tick_t s_next;

    ////////////////////////////////////////////////////////////////////////
    // two-stage synchroniser, edge seen between stage two and three only
    always_comb begin
        s_next       = s_reg;
        s_next.sync1 = lsClk;
        s_next.sync2 = s_reg.sync1;
        s_next.sync3 = s_reg.sync2;
        // no ticks in low power: the real oscillator is off there anyway
        s_next.tick  = s_reg.sync2 & ~s_reg.sync3 & ~lowPower;
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign lsTick = s_reg.tick;
endmodule
`default_nettype wire

/* File: hdl/rct_countdown_timer.sv */
`include "rct_consts.svh"
`default_nettype none
module rct_countdown_timer
    import rct_pkg::*;
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rstn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // low-speed clock and power state
    input  wire logic        lsClk,
    input  wire logic        lowPower,
    // interrupt
    output logic             combinedIrq
);
    rct_state_t s_reg;
    rct_state_t s_next;
    logic       lsTick;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // true for the four pattern words; alignment is left to isMapped
    function automatic logic isPattern(input logic [11:0] a);
        return (a >= `RCT_OFS_TPR1) && (a <= `RCT_OFS_TPR4);
    endfunction

    // true when the byte address names a register of this block
    function automatic logic isMapped(input logic [11:0] a);
        logic hit;
        hit = 1'b0;
        case (a)
            `RCT_OFS_IMSC, `RCT_OFS_RIS, `RCT_OFS_MIS, `RCT_OFS_ICR,
            `RCT_OFS_TDR, `RCT_OFS_TCR, `RCT_OFS_TLR1, `RCT_OFS_TLR2,
            `RCT_OFS_TIN: begin
                hit = 1'b1;
            end
            default: begin
                hit = isPattern(a) && (a[1:0] == 2'b00);
            end
        endcase
        return hit;
    endfunction

    // word index 0..3 of a pattern register
    function automatic logic [1:0] patWord(input logic [11:0] a);
        logic [11:0] d;
        d = a - `RCT_OFS_TPR1;
        return d[3:2];
    endfunction

    // reload value selected by the current pattern bit
    function automatic logic [31:0] pickReload(input rct_state_t st);
        return st.pattern[st.patIdx] ? st.reload2 : st.reload1;
    endfunction

    // countdown started from a given value; the pattern always restarts at bit 0
    function automatic rct_state_t startRun(input rct_state_t st, input logic [31:0] first);
        rct_state_t ns;
        ns        = st;
        ns.tstate = RCT_RUNNING;
        ns.count  = first;
        ns.patIdx = '0;
        return ns;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // low-speed tick, synchronised and gated by low power
    rct_ls_tick u_tick (
        .mclk     (mclk),
        .rstn     (rstn),
        .lsClk    (lsClk),
        .lowPower (lowPower),
        .lsTick   (lsTick)
    );

    ////////////////////////////////////////////////////////////////////////
    // next-state logic: countdown first, then register writes on top
    always_comb begin
        logic        setup;
        logic        wrEn;
        logic        running;
        logic        irqSet;
        logic        irqClr;
        logic [31:0] rd;
        setup   = psel & ~penable;
        wrEn    = psel & penable & pwrite & isMapped(paddr);
        running = (s_reg.tstate == RCT_RUNNING);
        irqSet  = 1'b0;
        irqClr  = 1'b0;
        rd      = '0;
        s_next  = s_reg;

        // countdown on each low-speed tick; tick is absent in low power
        if (running && lsTick) begin
            if (s_reg.count == '0) begin
                irqSet = 1'b1;
                s_next.irqNumber = s_reg.irqNumber + 32'h00000001;
                if (s_reg.oneshotSelect) begin
                    // one-shot stays at zero until restarted
                    s_next.tstate = RCT_HALTED;
                end else begin
                    // automatic restart from the pattern-chosen value
                    s_next.count = pickReload(s_reg);
                    // wrap after patLen+1 bits of the 128-bit pattern
                    if (s_reg.patIdx >= s_reg.patLen) begin
                        s_next.patIdx = '0;
                    end else begin
                        s_next.patIdx = s_reg.patIdx + 7'h01;
                    end
                end
            end else begin
                s_next.count = s_reg.count - 32'h00000001;
            end
        end

        // register writes, taken at the access edge, legal while running
        if (wrEn) begin
            case (paddr)
                `RCT_OFS_IMSC: begin
                    s_next.irqMask = pwdata[`RCT_IRQ_TMR];
                end
                `RCT_OFS_ICR: begin
                    irqClr = pwdata[`RCT_IRQ_TMR];
                end
                `RCT_OFS_TCR: begin
                    s_next.oneshotSelect = pwdata[`RCT_TCR_OS];
                    s_next.selfStart     = pwdata[`RCT_TCR_SS];
                    s_next.patLen        = pwdata[`RCT_TCR_PLEN_HI:`RCT_TCR_PLEN_LO];
                    if (!pwdata[`RCT_TCR_RUN]) begin
                        // software stop in either mode
                        s_next.tstate = RCT_STOPPED;
                    end else if (!running) begin
                        // software start always begins from the first value
                        s_next = startRun(s_next, s_reg.reload1);
                    end
                end
                `RCT_OFS_TLR1: begin
                    // a running counter keeps its reload values untouched
                    if (!running) begin
                        s_next.reload1 = pwdata;
                        // one-shot restarts on a new first value
                        if (s_reg.selfStart || s_reg.oneshotSelect) begin
                            s_next = startRun(s_next, pwdata);
                        end
                    end
                end
                `RCT_OFS_TLR2: begin
                    if (!running) begin
                        s_next.reload2 = pwdata;
                        if (s_reg.selfStart) begin
                            // self-start still begins from the first value
                            s_next = startRun(s_next, s_reg.reload1);
                        end
                    end
                end
                default: begin
                    // pattern words; status, count and number are read-only
                    if (isPattern(paddr)) begin
                        s_next.pattern[patWord(paddr)*32 +: 32] = pwdata;
                    end
                end
            endcase
        end

        // sticky flag: a zero reached in the clearing cycle is kept
        if (irqClr) begin
            s_next.countdownIrq = 1'b0;
        end
        if (irqSet) begin
            s_next.countdownIrq = 1'b1;
        end

        // single source here, so the OR reduces to the masked timer flag
        s_next.combinedIrq = s_next.countdownIrq & s_next.irqMask;

        // read data captured in the setup cycle, stable through access
        if (setup) begin
            case (paddr)
                `RCT_OFS_IMSC: begin
                    rd[`RCT_IRQ_TMR] = s_reg.irqMask;
                end
                `RCT_OFS_RIS: begin
                    rd[`RCT_IRQ_TMR] = s_reg.countdownIrq;
                end
                `RCT_OFS_MIS: begin
                    rd[`RCT_IRQ_TMR] = s_reg.countdownIrq & s_reg.irqMask;
                end
                `RCT_OFS_TDR: begin
                    rd = s_reg.count;
                end
                `RCT_OFS_TCR: begin
                    rd[`RCT_TCR_RUN] = running;
                    rd[`RCT_TCR_OS]  = s_reg.oneshotSelect;
                    rd[`RCT_TCR_SS]  = s_reg.selfStart;
                    rd[`RCT_TCR_PLEN_HI:`RCT_TCR_PLEN_LO] = s_reg.patLen;
                end
                `RCT_OFS_TLR1: begin
                    rd = s_reg.reload1;
                end
                `RCT_OFS_TLR2: begin
                    rd = s_reg.reload2;
                end
                `RCT_OFS_TIN: begin
                    rd = s_reg.irqNumber;
                end
                default: begin
                    if (isMapped(paddr) && isPattern(paddr)) begin
                        rd = s_reg.pattern[patWord(paddr)*32 +: 32];
                    end
                end
            endcase
            s_next.rdData = rd;
            s_next.rdErr  = ~isMapped(paddr);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            s_reg               <= '0;
            s_reg.tstate        <= RCT_STOPPED;
            s_reg.count         <= `RCT_TDR_RST;
            s_reg.patLen        <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs; zero wait states keep the bus simple at this low traffic
    assign pready      = 1'b1;
    assign prdata      = s_reg.rdData;
    assign pslverr     = s_reg.rdErr & psel & penable;
    assign combinedIrq = s_reg.combinedIrq;
endmodule
`default_nettype wire

/* File: tb/rct_countdown_timer_monitor.sv */
`include "rct_consts.svh"
`default_nettype none
module rct_countdown_timer_monitor
    import rct_pkg::*;
(
    // system side
    input wire logic        mclk,
    input wire logic        rstn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // timer
    input wire logic        lsClk,
    input wire logic        lowPower,
    input wire logic        combinedIrq
);
    logic       acc;
    logic       mapped;
    logic       lsPrev_reg;
    logic [3:0] cause_reg;
    logic [3:0] clr_reg;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////////////////////
    // access phase and decode of the register map
    assign acc = psel && penable;
    assign mapped = paddr[1:0] == 2'h0 && paddr >= `RCT_OFS_IMSC && paddr <= `RCT_OFS_TIN;
    // cycles since a possible cause; saturate so a quiet spell never looks recent
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            lsPrev_reg <= 1'b0;
            cause_reg <= 4'hF;
            clr_reg <= 4'hF;
        end else begin
            lsPrev_reg <= lsClk;
            cause_reg <= (lsClk && !lsPrev_reg && !lowPower) || (acc && pwrite)
                ? 4'h0 : cause_reg + {3'h0, cause_reg != 4'hF};
            clr_reg <= acc && pwrite && paddr inside {`RCT_OFS_IMSC, `RCT_OFS_ICR}
                ? 4'h0 : clr_reg + {3'h0, clr_reg != 4'hF};
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    ready_high_a: assert property (pready) else $error("pready low");
    err_access_a: assert property (pslverr |-> acc) else $error("stray pslverr");
    err_unmapped_a: assert property (acc && !mapped |-> pslverr)
        else $error("no error on unmapped place");
    err_mapped_a: assert property (acc && mapped |-> !pslverr)
        else $error("error on mapped place");
    rd_unmapped_a: assert property (acc && !pwrite && !mapped |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    rd_hold_a: assert property (acc && !pwrite ##1 !(psel && !penable)
        |-> $stable(prdata)) else $error("read data moved after access");
    mask_off_a: assert property (acc && pwrite && paddr == `RCT_OFS_IMSC && !pwdata[0]
        |-> ##[1:3] !combinedIrq) else $error("masked interrupt still high");
    irq_cause_a: assert property ($rose(combinedIrq) |-> cause_reg < 4'hA)
        else $error("interrupt without tick or unmask");
    irq_hold_a: assert property ($fell(combinedIrq) |-> clr_reg < 4'h4)
        else $error("interrupt dropped without clear");
    irq_rise_c: cover property ($rose(combinedIrq));
    irq_fall_c: cover property ($fell(combinedIrq));
    err_seen_c: cover property (acc && pslverr);
endmodule
bind rct_countdown_timer rct_countdown_timer_monitor u_rct_countdown_timer_monitor (
    .mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lsClk(lsClk), .lowPower(lowPower), .combinedIrq(combinedIrq));
`default_nettype wire

/* File: tb/rct_countdown_timer_tb_top.sv */
`include "rct_consts.svh"
`default_nettype none
module rct_countdown_timer_tb_top
    import rct_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        mclk = 1'b0;
    logic        rstn, psel, penable, pwrite, lsClk, lowPower;
    logic        pready, pslverr, combinedIrq, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, d, r1, r2, rel, pat;
    int          seed = 90624;
    int          failCount = 0;
    int          checksDone = 0;
    int          tinExp = 0;
    int          idx, len;
    always #2.5 mclk = ~mclk;
    rct_countdown_timer u_rct_countdown_timer (
        .mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .lsClk(lsClk), .lowPower(lowPower), .combinedIrq(combinedIrq));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic reportAndStop();
        $display("checks %0d mismatches %0d", checksDone, failCount);
        if (failCount == 0 && checksDone > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic checkWord(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp) begin
            failCount++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic checkBit(input logic got, input logic exp);
        checksDone++;
        if (got !== exp) begin
            failCount++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one transfer; answer and read data taken at the edge that samples pready high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rdChk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        checkWord(d, exp);
    endtask
    // control writes are spaced well past three low-speed periods
    task automatic wrTcr(input logic [31:0] wd);
        apb(1'b1, `RCT_OFS_TCR, wd);
        repeat (30) @(posedge mclk);
    endtask
    // low-speed edges only on demand, so every count is exact
    task automatic lsTicks(input int n);
        repeat (n) begin
            lsClk <= 1'b1;
            repeat (4) @(posedge mclk);
            lsClk <= 1'b0;
            repeat (4) @(posedge mclk);
        end
    endtask
    function automatic logic [31:0] nextRel(input int i);
        return pat[i] ? r2 : r1;
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {rstn, psel, penable, pwrite, lsClk, lowPower} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (20) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        // reset contents, the write-only clear place skipped
        for (int i = 0; i < 13; i++) begin
            if (i != 3) begin
                rdChk(`RCT_OFS_IMSC + 12'(4 * i), i == 4 ? `RCT_TDR_RST : 32'h0);
            end
        end
        apb(1'b1, 12'h054, 32'hFFFFFFFF);
        checkBit(e, 1'b1);
        // periodic run with random reloads, pattern and length
        r1 = 32'h2 + 32'({$random(seed)} % 4);
        r2 = 32'h2 + 32'({$random(seed)} % 4);
        pat = $random(seed);
        len = {$random(seed)} % 4;
        apb(1'b1, `RCT_OFS_TLR1, r1);
        apb(1'b1, `RCT_OFS_TLR2, r2);
        apb(1'b1, `RCT_OFS_TPR1, pat);
        apb(1'b1, `RCT_OFS_IMSC, 32'h1);
        wrTcr({21'h0, 7'(len), 4'h1});
        rdChk(`RCT_OFS_TDR, r1);
        apb(1'b1, `RCT_OFS_TLR1, 32'h000000FF);
        rdChk(`RCT_OFS_TLR1, r1);
        rel = r1;
        idx = 0;
        for (int k = 0; k < 6; k++) begin
            lsTicks(int'(rel));
            rdChk(`RCT_OFS_RIS, 32'h0);
            lsTicks(1);
            tinExp++;
            checkBit(combinedIrq, 1'b1);
            rdChk(`RCT_OFS_RIS, 32'h1);
            rdChk(`RCT_OFS_TIN, 32'(tinExp));
            apb(1'b1, `RCT_OFS_ICR, 32'h1);
            rdChk(`RCT_OFS_RIS, 32'h0);
            rel = nextRel(idx);
            idx = (idx == len) ? 0 : idx + 1;
            rdChk(`RCT_OFS_TDR, rel);
        end
        // low-power freezes the count
        lowPower <= 1'b1;
        lsTicks(3);
        rdChk(`RCT_OFS_TDR, rel);
        lowPower <= 1'b0;
        wrTcr(32'h0);
        apb(1'b1, `RCT_OFS_TLR1, 32'h3);
        rdChk(`RCT_OFS_TLR1, 32'h3);
        // one-shot: one interrupt, then halt at zero
        wrTcr(32'h3);
        lsTicks(4);
        tinExp++;
        rdChk(`RCT_OFS_TCR, 32'h2);
        lsTicks(2);
        rdChk(`RCT_OFS_TDR, 32'h0);
        rdChk(`RCT_OFS_TIN, 32'(tinExp));
        // masking hides the flag but keeps the raw status
        apb(1'b1, `RCT_OFS_IMSC, 32'h0);
        rdChk(`RCT_OFS_MIS, 32'h0);
        rdChk(`RCT_OFS_RIS, 32'h1);
        checkBit(combinedIrq, 1'b0);
        apb(1'b1, `RCT_OFS_IMSC, 32'h1);
        rdChk(`RCT_OFS_MIS, 32'h1);
        apb(1'b1, `RCT_OFS_ICR, 32'h1);
        // a first-reload write restarts; zero gives the one-tick period
        apb(1'b1, `RCT_OFS_TLR1, 32'h0);
        rdChk(`RCT_OFS_TCR, 32'h3);
        lsTicks(1);
        tinExp++;
        rdChk(`RCT_OFS_TIN, 32'(tinExp));
        // self-start: a second-reload write sets run enable
        wrTcr(32'h6);
        apb(1'b1, `RCT_OFS_TLR2, 32'h5);
        rdChk(`RCT_OFS_TCR, 32'h7);
        reportAndStop();
    end
    // hang guard, over twenty-five times the expected run
    initial begin
        repeat (20000) @(posedge mclk);
        failCount++;
        reportAndStop();
    end
endmodule
`default_nettype wire
